//--- idm_map.svh
// Register offsets, field positions, reset values and encodings for the
// destination match block. Included by the match module, the top module and the bench.
`ifndef IDM_MAP_SVH
`define IDM_MAP_SVH
`define IDM_OFF_CMD_LO     8'h00
`define IDM_OFF_CMD_HI     8'h04
`define IDM_OFF_LOGID      8'h08
`define IDM_OFF_MODEL      8'h0c
`define IDM_OFF_LOCALID    8'h10
`define IDM_OFF_CFG        8'h14
`define IDM_OFF_SENT       8'h18
`define IDM_OFF_SENT_HI    8'h1c
`define IDM_OFF_RXSTAT     8'h20
`define IDM_RST_MODEL      32'hffff_ffff
`define IDM_RST_LOGID      32'h0000_0000
`define IDM_RST_LOCALID    8'h00
`define IDM_MODEL_MSB      31
`define IDM_MODEL_LSB      28
`define IDM_MODEL_FLAT     4'hf
`define IDM_MODEL_CLUSTER  4'h0
`define IDM_LID_MSB        31
`define IDM_LID_LSB        24
`define IDM_VEC_MSB        7
`define IDM_DLV_MSB        10
`define IDM_DLV_LSB        8
`define IDM_DSTMODE_BIT    11
`define IDM_LEVEL_BIT      14
`define IDM_TRIG_BIT       15
`define IDM_SH_MSB         19
`define IDM_SH_LSB         18
`define IDM_DEST_MSB       31
`define IDM_DEST_LSB       24
`define IDM_BCAST_NEW      8'hff
`define IDM_BCAST_OLD      4'hf
`endif

//--- idm_match.sv
// Combinational receive-side acceptance check for one message.
// Assumes the format and logical id words are stable register values.
`timescale 1ns/100ps
`include "idm_map.svh"
module idm_match
  import idm_pkg::*;
(
  input  wire logic        legacy_bus,
  input  wire logic        dst_logical,
  input  wire logic [7:0]  dst_addr,
  input  wire logic [7:0]  local_id,
  input  wire logic [31:0] logid,
  input  wire logic [31:0] model,
  output logic             accept,
  output logic             broadcast
);
  logic [3:0] fmt;
  logic       phys_hit;
  logic       phys_bc;
  logic       flat_hit;
  logic       clus_hit;
  logic [7:0] lid;
  assign fmt = model[`IDM_MODEL_MSB:`IDM_MODEL_LSB];
  assign lid = logid[`IDM_LID_MSB:`IDM_LID_LSB];
  // Wide bus: FFH broadcast, else exact id.
  // Narrow bus: 0FH broadcast, four-bit ids.
  assign phys_bc  = legacy_bus ? (dst_addr[3:0] == `IDM_BCAST_OLD)
                               : (dst_addr == `IDM_BCAST_NEW);
  assign phys_hit = phys_bc | (legacy_bus ? (dst_addr[3:0] == local_id[3:0])
                                          : (dst_addr == local_id));
  // Flat AND match; all ones hits any nonzero id.
  assign flat_hit = |(dst_addr & lid);
  // Cluster compare; cluster 15 only as broadcast; all ones.
  assign clus_hit = (dst_addr == `IDM_BCAST_NEW) |
                    ((dst_addr[7:4] == lid[7:4]) && (dst_addr[7:4] != 4'hf)
                     && |(dst_addr[3:0] & lid[3:0]));
  // Logical path uses format; 0000 picks cluster.
  always_comb begin
    if (!dst_logical) begin
      accept    = phys_hit;
      broadcast = phys_bc;
    end else if (fmt == `IDM_MODEL_FLAT) begin
      accept    = flat_hit;
      broadcast = dst_addr == `IDM_BCAST_NEW;
    end else if (fmt == `IDM_MODEL_CLUSTER) begin
      accept    = clus_hit;
      broadcast = dst_addr == `IDM_BCAST_NEW;
    end else begin
      accept    = 1'b0;
      broadcast = 1'b0;
    end
  end
endmodule : idm_match

//--- idm_peer.sv
// Partner model: another interrupt unit on the shared bus sending messages.
// Assumes the caller runs on the same clock as the block.
`timescale 1ns/100ps
module idm_peer (
  input  wire logic       clk,
  output logic            valid,
  output logic            logical,
  output logic      [7:0] dest
);
  initial begin
    valid   = 1'b0;
    logical = 1'b0;
    dest    = 8'h00;
  end

  // Peers are present, share one format and send no lowest-priority broadcast.
  task automatic send(input logic l, input logic [7:0] d);
    @(posedge clk);
    valid   <= 1'b1;
    logical <= l;
    dest    <= d;
    @(posedge clk);
    valid   <= 1'b0;
    // Released lines show the inverse, so a late sample is caught.
    logical <= ~l;
    dest    <= ~d;
  endtask : send
endmodule : idm_peer

//--- idm_pkg.sv
// Types shared by the destination match block.
// Assumes idm_map.svh is on the include path.
package idm_pkg;
  typedef enum logic [2:0] {
    IDM_DLV_FIXED  = 3'h0,
    IDM_DLV_LOWPRI = 3'h1,
    IDM_DLV_SMI    = 3'h2,
    IDM_DLV_RSVD   = 3'h3,
    IDM_DLV_NMI    = 3'h4,
    IDM_DLV_INIT   = 3'h5,
    IDM_DLV_START  = 3'h6,
    IDM_DLV_EXT    = 3'h7
  } idm_dlv_t;
  typedef enum logic [1:0] {
    IDM_SH_NONE = 2'h0,
    IDM_SH_SELF = 2'h1,
    IDM_SH_ALL  = 2'h2,
    IDM_SH_OTHR = 2'h3
  } idm_sh_t;
  typedef enum logic [1:0] {
    IDM_ST_IDLE = 2'h0,
    IDM_ST_SEND = 2'h1
  } idm_state_t;
endpackage : idm_pkg

//--- idm_top.sv
// Destination selection and acceptance for interprocessor messages.
// Assumes a simple register port on CLK and messages presented by the
// shared interrupt bus logic on the same clock.
// Notes on behaviour
// - Narrow bus: level fixed/lowpri/NMI with level bit 1 goes as edge.
// - Narrow bus level init: level 1 edge init, level 0 deassert sync.
// - Wide bus: a level trigger setting is ignored and sent edge.
// - Lowest priority to all-but-self may also come back to sender.
// - Wide bus physical: 00-FE single target, FF broadcast.
// - Narrow bus physical: 0-E single target, F broadcast.
// - Logical messages match against logical id and format registers.
// - Format 1111 selects flat: accept when address AND id nonzero.
// - Flat all-ones address reaches every unit with a nonzero logical id.
// - Format 0000 selects the cluster model.
// - Cluster: high nibble picks cluster, low nibble picks members.
// - Clusters 0 to 14 with four members each.
// - Cluster all-ones address matches every member.
// - Format register resets to the flat model.
// - Shorthand: 00 none, 01 self, 10 all, 11 all but self.
`timescale 1ns/100ps
`include "idm_map.svh"
module idm_top
  import idm_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic        RX_VALID,
  input  wire logic        RX_LOGICAL,
  input  wire logic [7:0]  RX_DEST,
  output logic             RX_DONE,
  output logic             RX_ACCEPT,
  output logic             TX_VALID,
  output logic      [31:0] TX_WORD,
  output logic      [7:0]  TX_DEST,
  output logic             TX_SELF,
  output logic             TX_OTHERS
);
  logic [31:0] cmd_hi_q;
  logic [31:0] logid_q;
  logic [31:0] model_q;
  logic [7:0]  local_id_q;
  logic        legacy_q;
  logic [31:0] sent_q;
  logic [7:0]  sent_dest_q;
  logic        last_acc_q;
  logic        last_bc_q;
  logic [7:0]  acc_cnt_q;
  logic        acc;
  logic        bc;
  logic [31:0] norm_d;
  logic [7:0]  dest_d;
  logic        self_d;
  logic        oth_d;
  logic        cmd_wr;
  idm_dlv_t    dlv;
  idm_sh_t     sh;

  assign cmd_wr = WR && (ADDR == `IDM_OFF_CMD_LO);
  assign dlv = idm_dlv_t'(WDATA[`IDM_DLV_MSB:`IDM_DLV_LSB]);
  assign sh  = idm_sh_t'(WDATA[`IDM_SH_MSB:`IDM_SH_LSB]);

  // Trigger normalisation for the outgoing word.
  always_comb begin
    norm_d = WDATA;
    if (legacy_q) begin
      if (WDATA[`IDM_TRIG_BIT] && dlv == IDM_DLV_INIT) begin
        // Level 0 stays as deassert sync, level 1 becomes edge init.
        if (WDATA[`IDM_LEVEL_BIT])
          norm_d[`IDM_TRIG_BIT] = 1'b0;
      end else if (WDATA[`IDM_TRIG_BIT] && WDATA[`IDM_LEVEL_BIT] &&
                   (dlv == IDM_DLV_FIXED || dlv == IDM_DLV_LOWPRI ||
                    dlv == IDM_DLV_NMI)) begin
        // Level with level bit 1 is sent edge.
        norm_d[`IDM_TRIG_BIT] = 1'b0;
      end
    end else begin
      // Wide bus ignores the level trigger setting.
      norm_d[`IDM_TRIG_BIT]  = 1'b0;
      norm_d[`IDM_LEVEL_BIT] = 1'b1;
    end
  end

  // Destination resolution from shorthand.
  always_comb begin
    dest_d = cmd_hi_q[`IDM_DEST_MSB:`IDM_DEST_LSB];
    self_d = 1'b0;
    oth_d  = 1'b0;
    unique case (sh)
      IDM_SH_NONE: begin
      end
      IDM_SH_SELF: begin
        self_d = 1'b1;
      end
      IDM_SH_ALL: begin
        self_d = 1'b1;
        oth_d  = 1'b1;
      end
      IDM_SH_OTHR: begin
        oth_d = 1'b1;
        // Lowest priority to others may also land on the sender.
        self_d = (dlv == IDM_DLV_LOWPRI);
      end
    endcase
    if (sh != IDM_SH_NONE)
      dest_d = legacy_q ? {4'h0, `IDM_BCAST_OLD} : `IDM_BCAST_NEW;
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      cmd_hi_q   <= 32'h0;
      logid_q    <= `IDM_RST_LOGID;
      model_q    <= `IDM_RST_MODEL;
      local_id_q <= `IDM_RST_LOCALID;
      legacy_q   <= 1'b0;
    end else if (WR) begin
      unique case (ADDR)
        `IDM_OFF_CMD_HI:  cmd_hi_q   <= WDATA;
        `IDM_OFF_LOGID:   logid_q    <= WDATA;
        `IDM_OFF_MODEL:   model_q    <= WDATA;
        `IDM_OFF_LOCALID: local_id_q <= WDATA[7:0];
        `IDM_OFF_CFG:     legacy_q   <= WDATA[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      TX_VALID    <= 1'b0;
      TX_WORD     <= 32'h0;
      TX_DEST     <= 8'h00;
      TX_SELF     <= 1'b0;
      TX_OTHERS   <= 1'b0;
      sent_q      <= 32'h0;
      sent_dest_q <= 8'h00;
    end else begin
      TX_VALID <= cmd_wr;
      if (cmd_wr) begin
        TX_WORD     <= norm_d;
        TX_DEST     <= dest_d;
        TX_SELF     <= self_d;
        TX_OTHERS   <= oth_d;
        sent_q      <= norm_d;
        sent_dest_q <= dest_d;
      end
    end
  end

  idm_match u_match (
    .legacy_bus  (legacy_q),
    .dst_logical (RX_LOGICAL),
    .dst_addr    (RX_DEST),
    .local_id    (local_id_q),
    .logid       (logid_q),
    .model       (model_q),
    .accept      (acc),
    .broadcast   (bc)
  );

  // One registered decision per received message.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RX_DONE    <= 1'b0;
      RX_ACCEPT  <= 1'b0;
      last_acc_q <= 1'b0;
      last_bc_q  <= 1'b0;
      acc_cnt_q  <= 8'h00;
    end else begin
      RX_DONE   <= RX_VALID;
      RX_ACCEPT <= RX_VALID && acc;
      if (RX_VALID) begin
        last_acc_q <= acc;
        last_bc_q  <= bc;
        if (acc)
          acc_cnt_q <= acc_cnt_q + 8'h01;
      end
    end
  end

  // Unmapped or write-only offsets read as zero.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RDATA <= 32'h0;
    end else if (RD) begin
      unique case (ADDR)
        `IDM_OFF_CMD_HI:  RDATA <= cmd_hi_q;
        `IDM_OFF_LOGID:   RDATA <= logid_q;
        `IDM_OFF_MODEL:   RDATA <= model_q;
        `IDM_OFF_LOCALID: RDATA <= {24'h0, local_id_q};
        `IDM_OFF_CFG:     RDATA <= {31'h0, legacy_q};
        `IDM_OFF_SENT:    RDATA <= sent_q;
        `IDM_OFF_SENT_HI: RDATA <= {24'h0, sent_dest_q};
        `IDM_OFF_RXSTAT:  RDATA <= {22'h0, last_bc_q, last_acc_q, acc_cnt_q};
        default:          RDATA <= 32'h0;
      endcase
    end else begin
      RDATA <= 32'h0;
    end
  end

  sequence s_rx_in;
    RX_VALID;
  endsequence

  AST_RX_ONE: assert property (@(posedge CLK) disable iff (SRST)
    s_rx_in |=> RX_DONE) else $error("receive decision missing");
  AST_RX_QUIET: assert property (@(posedge CLK) disable iff (SRST)
    !RX_VALID |=> !RX_DONE && !RX_ACCEPT) else $error("spurious accept");
  AST_PHYS_BC: assert property (@(posedge CLK) disable iff (SRST)
    RX_VALID && !RX_LOGICAL && !legacy_q && RX_DEST == 8'hff |=> RX_ACCEPT)
    else $error("physical broadcast not accepted");
  AST_OLD_BC: assert property (@(posedge CLK) disable iff (SRST)
    RX_VALID && !RX_LOGICAL && legacy_q && RX_DEST[3:0] == 4'hf |=> RX_ACCEPT)
    else $error("narrow broadcast not accepted");
  AST_FLAT: assert property (@(posedge CLK) disable iff (SRST)
    RX_VALID && RX_LOGICAL && model_q[31:28] == 4'hf
    |=> RX_ACCEPT == $past(|(RX_DEST & logid_q[31:24])))
    else $error("flat match wrong");
  AST_CLUS_BC: assert property (@(posedge CLK) disable iff (SRST)
    RX_VALID && RX_LOGICAL && model_q[31:28] == 4'h0 && RX_DEST == 8'hff
    |=> RX_ACCEPT) else $error("cluster broadcast not accepted");
  AST_CLUS_MISS: assert property (@(posedge CLK) disable iff (SRST)
    RX_VALID && RX_LOGICAL && model_q[31:28] == 4'h0 && RX_DEST != 8'hff &&
    RX_DEST[7:4] != logid_q[31:28] |=> !RX_ACCEPT)
    else $error("wrong cluster accepted");
  AST_NEW_EDGE: assert property (@(posedge CLK) disable iff (SRST)
    cmd_wr && !legacy_q |=> TX_VALID && !TX_WORD[15])
    else $error("level trigger sent on wide bus");
  AST_INIT_DEASSERT: assert property (@(posedge CLK) disable iff (SRST)
    cmd_wr && legacy_q && dlv == IDM_DLV_INIT && WDATA[15] && !WDATA[14]
    |=> TX_WORD[15] && !TX_WORD[14]) else $error("deassert lost");
  AST_FIX_EDGE: assert property (@(posedge CLK) disable iff (SRST)
    cmd_wr && legacy_q && dlv == IDM_DLV_FIXED && WDATA[15] && WDATA[14]
    |=> !TX_WORD[15]) else $error("level fixed not edge");
  AST_SH_ALL: assert property (@(posedge CLK) disable iff (SRST)
    cmd_wr && sh == IDM_SH_ALL |=> TX_SELF && TX_OTHERS)
    else $error("all shorthand wrong");
  AST_RST_FLAT: assert property (@(posedge CLK)
    SRST |=> model_q[31:28] == 4'hf) else $error("format not flat after reset");
endmodule : idm_top

//--- idm_top_tb.sv
// Self-checking bench for the destination match block.
// Assumes idm_map.svh on the include path and the peer model beside it.
`timescale 1ns/100ps
`include "idm_map.svh"
module idm_top_tb
  import idm_pkg::*;
;
  logic        CLK, SRST, WR, RD, RX_VALID, RX_LOGICAL, RX_DONE, RX_ACCEPT;
  logic        TX_VALID, TX_SELF, TX_OTHERS;
  logic [7:0]  ADDR, RX_DEST, TX_DEST;
  logic [31:0] WDATA, RDATA, TX_WORD;
  int          num_errors, samples_checked, cycles;

  always #50 CLK = ~CLK;

  idm_top dut_u (
    .CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .RX_VALID(RX_VALID), .RX_LOGICAL(RX_LOGICAL), .RX_DEST(RX_DEST),
    .RX_DONE(RX_DONE), .RX_ACCEPT(RX_ACCEPT), .TX_VALID(TX_VALID), .TX_WORD(TX_WORD),
    .TX_DEST(TX_DEST), .TX_SELF(TX_SELF), .TX_OTHERS(TX_OTHERS)
  );

  idm_peer peer_u (.clk(CLK), .valid(RX_VALID), .logical(RX_LOGICAL), .dest(RX_DEST));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR    <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD   <= 1'b0;
    #1 chk(RDATA, exp);
  endtask : rdc

  task automatic tx(input logic [31:0] lo, input logic [31:0] elo, input logic [7:0] edst,
                    input logic [1:0] eso);
    wr(`IDM_OFF_CMD_LO, lo);
    #1 chk(TX_VALID, 1'b1);
    chk(TX_WORD, elo);
    chk(TX_DEST, edst);
    chk({TX_SELF, TX_OTHERS}, eso);
  endtask : tx

  task automatic rx(input logic l, input logic [7:0] d, input logic acc);
    peer_u.send(l, d);
    #1 chk(RX_DONE, 1'b1);
    chk(RX_ACCEPT, acc);
  endtask : rx

  // Hang guard; a full run needs well under a thousand cycles.
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    logic [31:0] lo;
    CLK = 1'b0;
    SRST = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 8'h00;
    WDATA = 32'h0;
    num_errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (2) @(posedge CLK);
    SRST <= 1'b0;
    rdc(`IDM_OFF_LOGID, 32'h0);
    wr(8'h3c, 32'h0);
    rdc(8'h3c, 32'h0);
    rdc(`IDM_OFF_MODEL, 32'hffff_ffff);
    $display("test reset done");
    wr(`IDM_OFF_CMD_HI, 32'h5a00_0000);
    for (int d = 0; d < 8; d++) begin
      // Level trigger stays off system-management and start-up commands.
      lo = {12'h000, 2'h3, 2'h0, (d != 2 && d != 6), 1'b1, 3'h0, d[2:0], 8'h00};
      tx(lo, lo & 32'hffff_7fff, 8'hff, (d == IDM_DLV_LOWPRI) ? 2'b11 : 2'b01);
    end
    tx(32'h0004_4000, 32'h0004_4000, 8'hff, 2'b10);
    tx(32'h0008_4000, 32'h0008_4000, 8'hff, 2'b11);
    tx(32'h0000_c000, 32'h0000_4000, 8'h5a, 2'b00);
    tx(32'h0000_8500, 32'h0000_4500, 8'h5a, 2'b00);
    $display("test wide send done");
    wr(`IDM_OFF_CFG, 32'h1);
    for (int d = 0; d < 8; d++) begin
      for (int l = 0; l < 2; l++) begin
        // Only the init deassert carries level 0; no level trigger on system-management and start-up commands.
        lo = {12'h000, 2'h0, 2'h0, (d != 2 && d != 6), l[0] | (d != 5), 3'h0, d[2:0], 8'h00};
        tx(lo, (lo[14] && d inside {0, 1, 4, 5}) ? lo & 32'hffff_7fff : lo, 8'h5a, 2'b00);
      end
    end
    tx(32'h0008_4000, 32'h0008_4000, 8'h0f, 2'b11);
    $display("test narrow send done");
    wr(`IDM_OFF_LOCALID, 32'h0000_0012);
    rx(1'b0, 8'h02, 1'b1);
    rx(1'b0, 8'h0f, 1'b1);
    rx(1'b0, 8'h0e, 1'b0);
    wr(`IDM_OFF_CFG, 32'h0);
    rx(1'b0, 8'h12, 1'b1);
    rx(1'b0, 8'h02, 1'b0);
    rx(1'b0, 8'hfe, 1'b0);
    rx(1'b0, 8'hff, 1'b1);
    $display("test physical done");
    wr(`IDM_OFF_LOGID, 32'h2400_0000);
    rx(1'b1, 8'h04, 1'b1);
    rx(1'b1, 8'h20, 1'b1);
    rx(1'b1, 8'hdb, 1'b0);
    rx(1'b1, 8'hff, 1'b1);
    $display("test flat done");
    wr(`IDM_OFF_MODEL, 32'h0fff_ffff);
    rdc(`IDM_OFF_MODEL, 32'h0fff_ffff);
    wr(`IDM_OFF_LOGID, 32'he200_0000);
    rx(1'b1, 8'he2, 1'b1);
    rx(1'b1, 8'he6, 1'b1);
    rx(1'b1, 8'he1, 1'b0);
    rx(1'b1, 8'hd2, 1'b0);
    rx(1'b1, 8'hff, 1'b1);
    wr(`IDM_OFF_MODEL, 32'h5fff_ffff);
    rx(1'b1, 8'he2, 1'b0);
    rx(1'b0, 8'h12, 1'b1);
    rdc(`IDM_OFF_RXSTAT, 32'h0000_010b);
    rdc(`IDM_OFF_SENT_HI, 32'h0000_000f);
    rdc(`IDM_OFF_SENT, 32'h0008_4000);
    rdc(`IDM_OFF_LOCALID, 32'h0000_0012);
    rdc(`IDM_OFF_CMD_HI, 32'h5a00_0000);
    $display("test cluster done");
    print_verdict();
  end
endmodule : idm_top_tb
